// ===== hdl/sdp_pkg.sv
// Shared constants and types for the synchronous dual-port RAM port
package sdp_pkg;
  localparam int SDP_DATA_W = 9;
  localparam int SDP_ADDR_W = 17;
  // Counter value after reset and after a counter clear
  localparam logic [SDP_ADDR_W-1:0] SDP_CNT_RESET = 17'h00000;
  localparam logic [SDP_ADDR_W-1:0] SDP_CNT_CLEAR = 17'h00000;
  // Output drive flags after reset: port not driving
  localparam logic SDP_DRIVE_RESET = 1'h0;
  // Step of the burst counter
  localparam logic SDP_CNT_STEP = 1'h1;
  // Read output mode, taken from the output mode select pin
  typedef enum logic
  {
    SDP_FLOW = 1'b0,
    SDP_PIPE = 1'b1
  } sdp_mode_t;
  localparam sdp_mode_t SDP_MODE_RESET = SDP_FLOW;
endpackage

// ===== hdl/sdp_mem_if.sv
// Access signals between the port logic and the shared memory array
`timescale 1ns/1ns
interface sdp_mem_if #(
  parameter int DW = sdp_pkg::SDP_DATA_W,
  parameter int AW = sdp_pkg::SDP_ADDR_W
);
  logic a_we;
  logic a_re;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic b_we;
  logic b_re;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_wdata;
  logic [DW-1:0] b_rdata;

  modport ctrl (
    output a_we, a_re, a_addr, a_wdata, b_we, b_re, b_addr, b_wdata,
    input a_rdata, b_rdata
  );
  modport mem (
    input a_we, a_re, a_addr, a_wdata, b_we, b_re, b_addr, b_wdata,
    output a_rdata, b_rdata
  );
endinterface

// ===== hdl/sdp_mem.sv
// True dual-port memory array with registered read data on both ports
`timescale 1ns/1ns
module sdp_mem #(
  parameter int DW = sdp_pkg::SDP_DATA_W,
  parameter int AW = sdp_pkg::SDP_ADDR_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  sdp_mem_if.mem mif
);
  logic [DW-1:0] ram [0:(2**AW)-1];

  // Both writes in one process; on a same-address clash port b lands last
  always_ff @(posedge clock)
  begin
    if (mif.a_we)
    begin
      ram[mif.a_addr] <= mif.a_wdata;
    end
    if (mif.b_we)
    begin
      ram[mif.b_addr] <= mif.b_wdata;
    end
  end

  // Reads see the old word when the other port writes the same cell
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mif.a_rdata <= '0;
    end
    else if (mif.a_re)
    begin
      mif.a_rdata <= ram[mif.a_addr];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mif.b_rdata <= '0;
    end
    else if (mif.b_re)
    begin
      mif.b_rdata <= ram[mif.b_addr];
    end
  end
endmodule // sdp_mem

// ===== hdl/sdp_port.sv
// One port of a synchronous dual-port RAM with burst counter and memory
// Behaviour
// - All port inputs except output enable are taken at the clock's edge.
// - Output enable high floats the data pins at once, clock regardless.
// - A sampled deselect floats the data pins after that edge in flow-through mode, one edge later in registered mode.
// - Mode select low gives flow-through reads, high gives registered reads.
// - Strobe held low loads the external address at every edge without a counter clear.
// - Access address is zero on clear, else the pins with strobe low, else the held or stepped counter.
// - Drive state of the data pins follows the previous cycle's controls, those of two cycles back in registered mode.
// - Selected write stores data at the edge; selected read drives the word.
// - Cross-port timing is the same in both directions in flow-through mode; registered mode adds a cycle to peer-to-port reads.
// - Counter clear costs no cycle; an access may share that edge.
// - Counter-driven writes act the same in both read modes.
// - Counter clear low sets the counter to zero above all else.
// - Counter loads on strobe, holds, or steps by one on advance.
// - Counter works regardless of both selects.
// - Registered reads appear one cycle after flow-through reads.
`timescale 1ns/1ns
module sdp_port #(
  parameter int DATA_W = sdp_pkg::SDP_DATA_W,
  parameter int ADDR_W = sdp_pkg::SDP_ADDR_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic output_enable_n,
  input wire logic select_low_active_n,
  input wire logic select_high_active,
  input wire logic read_write,
  input wire logic addr_capture_strobe_n,
  input wire logic count_advance_n,
  input wire logic counter_clear_n,
  input wire logic output_mode_select,
  input wire logic peer_we,
  input wire logic peer_re,
  input wire logic [ADDR_W-1:0] peer_addr,
  input wire logic [DATA_W-1:0] peer_wdata,
  output logic [DATA_W-1:0] peer_rdata
);
  logic sel;
  logic [ADDR_W-1:0] cnt_q;
  logic [ADDR_W-1:0] cnt_d;
  sdp_pkg::sdp_mode_t mode_q;
  logic drive1_q;
  logic drive2_q;
  logic [DATA_W-1:0] pipe_q;

  sdp_mem_if #(.DW(DATA_W), .AW(ADDR_W)) mif ();

  sdp_mem #(.DW(DATA_W), .AW(ADDR_W)) u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .mif(mif)
  );

  // Both selects must be active; banks share address lines
  assign sel = !select_low_active_n && select_high_active;

  // Burst counter next value; selects play no part
  always_comb
  begin
    if (!counter_clear_n)
    begin
      cnt_d = sdp_pkg::SDP_CNT_CLEAR;
    end
    else if (!addr_capture_strobe_n)
    begin
      cnt_d = addr;
    end
    else if (!count_advance_n)
    begin
      // Natural binary wrap from the top address to zero
      cnt_d = cnt_q + ADDR_W'(sdp_pkg::SDP_CNT_STEP);
    end
    else
    begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_q <= sdp_pkg::SDP_CNT_RESET;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Access address is the counter's new value: pins under strobe, zero
  // under clear, so a cleared cycle still carries an access
  assign mif.a_addr = cnt_d;
  assign mif.a_wdata = data_in;
  assign mif.a_we = sel && !read_write;
  assign mif.a_re = sel && read_write;
  assign mif.b_we = peer_we;
  assign mif.b_re = peer_re;
  assign mif.b_addr = peer_addr;
  assign mif.b_wdata = peer_wdata;
  assign peer_rdata = mif.b_rdata;

  // Mode pin is a strap in practice; sampling it keeps it on the clock
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mode_q <= sdp_pkg::SDP_MODE_RESET;
    end
    else
    begin
      mode_q <= sdp_pkg::sdp_mode_t'(output_mode_select);
    end
  end

  // First drive flag holds last cycle's read decision, second the one before
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      drive1_q <= sdp_pkg::SDP_DRIVE_RESET;
      drive2_q <= sdp_pkg::SDP_DRIVE_RESET;
    end
    else
    begin
      drive1_q <= sel && read_write;
      drive2_q <= drive1_q;
    end
  end

  // Output register of the pipelined mode
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pipe_q <= '0;
    end
    else
    begin
      pipe_q <= mif.a_rdata;
    end
  end

  // Data and enable pass through a mode mux; output enable must act
  // without the clock, so it cannot sit behind a flip-flop
  always_comb
  begin
    if (mode_q == sdp_pkg::SDP_PIPE)
    begin
      data_out = pipe_q;
      data_oe = !output_enable_n && drive2_q;
    end
    else
    begin
      data_out = mif.a_rdata;
      data_oe = !output_enable_n && drive1_q;
    end
  end

  a_oe_float: assert property (
    @(posedge clock) disable iff (!rst_n)
    output_enable_n |-> !data_oe)
    else $error("data driven while output enable is high");

  a_flow_deselect: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!sel && mode_q == sdp_pkg::SDP_FLOW
      && output_mode_select == 1'b0) |=> !data_oe)
    else $error("flow-through port drives after deselect");

  a_pipe_deselect: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!sel ##1 (!sel && mode_q == sdp_pkg::SDP_PIPE
      && output_mode_select == 1'b1)) |=> !data_oe)
    else $error("pipelined port drives after deselect");

  a_cnt_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    !counter_clear_n |=> cnt_q == sdp_pkg::SDP_CNT_CLEAR)
    else $error("counter not zero after clear");

  a_cnt_load: assert property (
    @(posedge clock) disable iff (!rst_n)
    (counter_clear_n && !addr_capture_strobe_n)
      |=> cnt_q == $past(addr))
    else $error("counter did not load the address");

  a_cnt_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    (counter_clear_n && addr_capture_strobe_n && count_advance_n)
      |=> $stable(cnt_q))
    else $error("counter moved while holding");

  a_cnt_step: assert property (
    @(posedge clock) disable iff (!rst_n)
    (counter_clear_n && addr_capture_strobe_n && !count_advance_n)
      |=> cnt_q == ADDR_W'($past(cnt_q) + ADDR_W'(1)))
    else $error("counter did not step by one");

  a_flow_wr_rd: assert property (
    @(posedge clock) disable iff (!rst_n)
    ((sel && !read_write && !peer_we && mode_q == sdp_pkg::SDP_FLOW)
      ##1 (sel && read_write && mif.a_addr == $past(mif.a_addr)
      && mode_q == sdp_pkg::SDP_FLOW))
      |=> data_out == $past(data_in, 2))
    else $error("flow-through read missed the written word");

  a_pipe_wr_rd: assert property (
    @(posedge clock) disable iff (!rst_n)
    ((sel && !read_write && !peer_we && mode_q == sdp_pkg::SDP_PIPE)
      ##1 (sel && read_write && mif.a_addr == $past(mif.a_addr)
      && mode_q == sdp_pkg::SDP_PIPE))
      |=> ##1 (mode_q != sdp_pkg::SDP_PIPE
      || data_out == $past(data_in, 3)))
    else $error("pipelined read missed the written word");
endmodule // sdp_port

// ===== tb/sdp_peer_model.sv
// Model of the far port: drives the peer access lines of the port
`timescale 1ns/1ns
module sdp_peer_model
(
  input wire logic clock,
  output logic we,
  output logic re,
  output logic [sdp_pkg::SDP_ADDR_W-1:0] addr,
  output logic [sdp_pkg::SDP_DATA_W-1:0] wdata,
  input wire logic [sdp_pkg::SDP_DATA_W-1:0] rdata
);
  initial
  begin
    we = 1'h0;
    re = 1'h0;
    addr = 17'h00000;
    wdata = 9'h000;
  end
  // One access, taken at the second edge; read data used just after that same edge
  task automatic access(input logic w, input logic [16:0] a,
    input logic [8:0] d, output logic [8:0] q);
    @(posedge clock);
    #2;
    we = w;
    re = !w;
    addr = a;
    wdata = d;
    @(posedge clock);
    #2;
    we = 1'h0;
    re = 1'h0;
    // Released address and data lines never keep the last value
    addr = ~a;
    wdata = ~d;
    q = rdata;
  endtask
endmodule // sdp_peer_model

// ===== tb/sync_dual_port_ram_port_tb.sv
// Self-checking bench for one port of the dual-port RAM
`timescale 1ns/1ns
module sync_dual_port_ram_port_tb;
  logic clock;
  logic rst_n;
  logic [16:0] addr;
  logic [8:0] data_in;
  logic [8:0] data_out;
  logic data_oe;
  logic oe_n;
  logic sel_n;
  logic sel_h;
  logic rw;
  logic ads_n;
  logic adv_n;
  logic clr_n;
  logic mode;
  logic p_we;
  logic p_re;
  logic [16:0] p_addr;
  logic [8:0] p_wdata;
  logic [8:0] p_rdata;
  logic [8:0] q;
  int miscompares = 0;
  int n_checks = 0;
  sdp_port dut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .output_enable_n(oe_n), .select_low_active_n(sel_n),
    .select_high_active(sel_h), .read_write(rw),
    .addr_capture_strobe_n(ads_n), .count_advance_n(adv_n),
    .counter_clear_n(clr_n), .output_mode_select(mode), .peer_we(p_we),
    .peer_re(p_re), .peer_addr(p_addr), .peer_wdata(p_wdata),
    .peer_rdata(p_rdata));
  sdp_peer_model peer (.clock(clock), .we(p_we), .re(p_re),
    .addr(p_addr), .wdata(p_wdata), .rdata(p_rdata));
  initial
  begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  task automatic chk_data(string n, logic [8:0] e);
    n_checks++;
    if (data_out !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, data_out);
      miscompares++;
    end
  endtask
  task automatic chk_flag(string n, logic e);
    n_checks++;
    if (data_oe !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, data_oe);
      miscompares++;
    end
  endtask
  task automatic chk_peer(string n, logic [8:0] e);
    n_checks++;
    if (q !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, q);
      miscompares++;
    end
  endtask
  // Present one cycle of controls, taken at the next edge
  task automatic acc(logic sn, logic sh, logic r, logic ld, logic ad,
    logic cl, logic [16:0] a, logic [8:0] d);
    sel_n = sn;
    sel_h = sh;
    rw = r;
    ads_n = ld;
    adv_n = ad;
    clr_n = cl;
    addr = a;
    data_in = r ? ~d : d;
    @(posedge clock);
    #2;
  endtask
  task automatic t_flow;
    acc(0, 1, 0, 0, 1, 1, 17'h00123, 9'h1A5);
    acc(0, 1, 0, 0, 1, 1, 17'h1F00F, 9'h05A);
    acc(0, 1, 1, 0, 1, 1, 17'h00123, 9'h000);
    chk_data("flow rd a", 9'h1A5);
    chk_flag("flow oe", 1'h1);
    oe_n = 1'h1;
    #1;
    chk_flag("oe async off", 1'h0);
    oe_n = 1'h0;
    acc(0, 0, 1, 0, 1, 1, 17'h1F00F, 9'h000);
    chk_flag("desel hi", 1'h0);
    acc(0, 1, 1, 0, 1, 1, 17'h1F00F, 9'h000);
    chk_flag("reselect oe", 1'h1);
    acc(1, 1, 1, 0, 1, 1, 17'h00123, 9'h000);
    chk_data("flow rd b", 9'h05A);
    acc(1, 1, 1, 0, 1, 1, 17'h00123, 9'h000);
    chk_flag("desel lo", 1'h0);
  endtask
  task automatic t_pipe;
    mode = 1'h1;
    acc(1, 1, 1, 0, 1, 1, 17'h00000, 9'h000);
    acc(0, 1, 1, 0, 1, 1, 17'h00123, 9'h000);
    acc(0, 1, 1, 0, 1, 1, 17'h1F00F, 9'h000);
    chk_data("pipe rd a", 9'h1A5);
    acc(1, 1, 1, 0, 1, 1, 17'h00000, 9'h000);
    chk_data("pipe rd b", 9'h05A);
    chk_flag("pipe oe held", 1'h1);
    acc(1, 1, 1, 0, 1, 1, 17'h00000, 9'h000);
    chk_flag("pipe desel", 1'h0);
    mode = 1'h0;
  endtask
  task automatic t_count;
    acc(0, 1, 0, 1, 1, 0, 17'h00055, 9'h011);
    acc(0, 1, 0, 1, 0, 1, 17'h00055, 9'h022);
    acc(0, 1, 0, 1, 1, 1, 17'h00055, 9'h033);
    acc(0, 1, 0, 0, 1, 1, 17'h1FFFF, 9'h044);
    acc(0, 1, 0, 1, 0, 1, 17'h00055, 9'h055);
    acc(1, 0, 1, 0, 1, 1, 17'h00001, 9'h000);
    acc(0, 1, 1, 1, 1, 1, 17'h00055, 9'h000);
    chk_data("cnt hold rd", 9'h033);
    acc(0, 1, 1, 0, 1, 1, 17'h00000, 9'h000);
    chk_data("cnt wrap", 9'h055);
    acc(0, 1, 1, 1, 0, 1, 17'h00000, 9'h000);
    chk_data("cnt adv rd", 9'h033);
  endtask
  task automatic t_peer;
    peer.access(1'h1, 17'h00777, 9'h1C3, q);
    acc(0, 1, 1, 0, 1, 1, 17'h00777, 9'h000);
    chk_data("peer to port", 9'h1C3);
    acc(0, 1, 0, 0, 1, 1, 17'h00888, 9'h0E7);
    peer.access(1'h0, 17'h00888, 9'h000, q);
    chk_peer("port to peer", 9'h0E7);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'h0;
    oe_n = 1'h0;
    mode = 1'h0;
    acc(1, 0, 1, 1, 1, 1, 17'h00000, 9'h000);
    repeat (19) @(posedge clock);
    #2;
    rst_n = 1'h1;
    t_flow;
    t_pipe;
    t_count;
    t_peer;
    stop_test;
  end
  initial
  begin
    repeat (2000) @(posedge clock);
    miscompares++;
    stop_test;
  end
endmodule // sync_dual_port_ram_port_tb
